// ==== logic/als_switchover.v ====
// alarm triggered switchover between a primary and a redundant serial line
//
// Chosen here: the address map and the APB register port.
`include "als_regs.vh"

// ---------------------------------------------------------------
// lead duration timer
// ---------------------------------------------------------------
module als_lead_timer (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire cond,
  input wire [9:0] dur,
  output wire hit
);
  reg [9:0] count;
  wire [9:0] need;

  // a zero duration behaves as one second
  assign need = (dur == 10'h000) ? 10'h001 : dur;
  assign hit = cond && (count >= need);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 10'h000;
    end else if (!cond) begin
      count <= 10'h000; // RULE13
    end else if (tick && (count < need)) begin
      count <= count + 10'h001; // RULE3
    end
  end
endmodule // als_lead_timer

// ---------------------------------------------------------------
// top level
// ---------------------------------------------------------------
module als_switchover #(
  parameter TICK_CYCLES = `ALS_TICK_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [11:0] port_a_lead,
  input wire [11:0] port_a_activity,
  input wire [11:0] port_b_lead,
  input wire [11:0] port_b_activity,
  input wire retained_switched,
  input wire key_unlocked,
  input wire gang_request,
  input wire gang_switched,
  input wire lamp_test,
  output reg switched,
  output wire active_port_b,
  output wire led_alarm,
  output wire led_line_a,
  output wire led_line_b,
  output wire led_inhibit,
  output wire irq
);
  localparam NL = `ALS_NUM_LEADS;

  // pending (software visible) and committed criteria
  reg pend_primary_b;
  reg act_primary_b;
  reg [23:0] pend_trig_state;
  reg [23:0] act_trig_state;
  reg [23:0] pend_inhib_state;
  reg [23:0] act_inhib_state;
  reg [1:0] pend_rst_state;
  reg [1:0] act_rst_state;
  reg [3:0] pend_rst_lead;
  reg [3:0] act_rst_lead;
  reg [9:0] pend_rst_dur;
  reg [9:0] act_rst_dur;
  reg [9:0] pend_trig_dur [0:NL-1];
  reg [9:0] act_trig_dur [0:NL-1];
  reg [9:0] pend_inhib_dur [0:NL-1];
  reg [9:0] act_inhib_dur [0:NL-1];
  reg [3:0] status;
  reg [3:0] mask;
  reg alarm;
  reg loaded;
  reg [31:0] tick_count;
  reg tick;
  integer i;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd_done = access && !pwrite;
  wire in_trig_dur = (paddr >= `ALS_OFF_TRIG_DUR) && (paddr < `ALS_OFF_TRIG_DUR + 12'h030);
  wire in_inhib_dur = (paddr >= `ALS_OFF_INHIB_DUR) && (paddr < `ALS_OFF_INHIB_DUR + 12'h030);
  wire [3:0] dur_idx = in_trig_dur ? paddr[5:2] : (paddr[5:2] - 4'h0);
  wire mapped = (paddr[1:0] == 2'h0) && ((paddr <= `ALS_OFF_POSITION) || in_trig_dur
                || in_inhib_dur);
  wire commit = wr && (paddr == `ALS_OFF_CTRL) && pwdata[`ALS_CTRL_COMMIT];
  wire discard = wr && (paddr == `ALS_OFF_CTRL) && pwdata[`ALS_CTRL_CLEAR] && !commit;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ---------------------------------------------------------------
  // one second timebase
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count <= 32'h00000000;
      tick <= 1'b0;
    end else if (tick_count >= TICK_CYCLES - 1) begin
      tick_count <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // lead conditions
  // ---------------------------------------------------------------
  function cond_of;
    input [1:0] code;
    input level;
    input activity;
    begin
      case (code)
        `ALS_CODE_MARK: cond_of = level;
        `ALS_CODE_SPACE: cond_of = !level;
        `ALS_CODE_NODATA: cond_of = !activity;
        default: cond_of = 1'b0; // RULE2
      endcase
    end
  endfunction

  // the other port is redundant with no setting of its own
  wire [11:0] pri_lead = act_primary_b ? port_b_lead : port_a_lead; // RULE1
  wire [11:0] pri_act = act_primary_b ? port_b_activity : port_a_activity;
  wire [11:0] red_lead = act_primary_b ? port_a_lead : port_b_lead; // RULE1
  wire [11:0] red_act = act_primary_b ? port_a_activity : port_b_activity;

  wire [11:0] trig_cond;
  wire [11:0] trig_hit;
  wire [11:0] inhib_cond;
  wire [11:0] inhib_hit;

  genvar g;
  generate
    for (g = 0; g < NL; g = g + 1) begin : lead
      assign trig_cond[g] = cond_of(act_trig_state[2*g+1:2*g], pri_lead[g], pri_act[g]);
      assign inhib_cond[g] = cond_of(act_inhib_state[2*g+1:2*g], red_lead[g], red_act[g]);
      als_lead_timer u_trig (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .cond(trig_cond[g]),
        .dur(act_trig_dur[g]),
        .hit(trig_hit[g])
      );
      als_lead_timer u_inhib (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .cond(inhib_cond[g]),
        .dur(act_inhib_dur[g]),
        .hit(inhib_hit[g])
      );
    end
  endgenerate

  // restore watches the primary lead for the complement of its setting
  wire [3:0] rst_idx = (act_rst_lead < 4'hC) ? act_rst_lead : 4'h0;
  reg rst_cond;
  always @* begin
    case (act_rst_state)
      `ALS_CODE_MARK: rst_cond = !pri_lead[rst_idx];
      `ALS_CODE_SPACE: rst_cond = pri_lead[rst_idx];
      `ALS_CODE_NODATA: rst_cond = pri_act[rst_idx];
      default: rst_cond = 1'b0;
    endcase
  end

  wire rst_hit;
  als_lead_timer u_restore (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .cond(rst_cond && (act_rst_lead < 4'hC)),
    .dur(act_rst_dur),
    .hit(rst_hit) // RULE5
  );

  wire inhibit = |inhib_hit; // RULE6
  wire trigger = |trig_hit; // RULE4

  // ---------------------------------------------------------------
  // switch position
  // ---------------------------------------------------------------
  wire gang_ok = gang_request && key_unlocked && (gang_switched != switched); // RULE10
  wire ev_switch = loaded && !gang_ok && !switched && trigger && !inhibit; // RULE4
  wire ev_fallback = loaded && !gang_ok && switched && rst_hit; // RULE5
  wire ev_inhibit = loaded && !switched && trigger && inhibit; // RULE6
  wire ev_gang = loaded && gang_ok;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switched <= 1'b0;
      loaded <= 1'b0;
      alarm <= 1'b0;
    end else if (!loaded) begin
      // position is taken from the retained store after reset release
      switched <= retained_switched; // RULE8
      loaded <= 1'b1;
    end else begin
      if (gang_ok) begin
        switched <= gang_switched; // RULE10
      end else if (ev_switch) begin
        switched <= 1'b1; // RULE4
      end else if (ev_fallback) begin
        switched <= 1'b0; // RULE5
      end
      if (ev_switch) begin
        alarm <= 1'b1;
      end else if (!switched || ev_fallback) begin
        alarm <= 1'b0;
      end
    end
  end

  assign active_port_b = act_primary_b ^ switched;

  // ---------------------------------------------------------------
  // indicators and interrupt
  // ---------------------------------------------------------------
  assign led_alarm = lamp_test || alarm; // RULE9
  assign led_line_a = lamp_test || !active_port_b; // RULE9
  assign led_line_b = lamp_test || active_port_b; // RULE9
  assign led_inhibit = lamp_test || inhibit; // RULE9
  assign irq = |(status & mask);

  wire [3:0] events = {ev_gang, ev_inhibit, ev_fallback, ev_switch};
  wire [3:0] status_rd = (rd_done && paddr == `ALS_OFF_STATUS) ? prdata[3:0] : 4'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 4'h0;
      mask <= 4'h0;
    end else begin
      // only bits seen by the read are cleared, so a new event is never lost
      status <= (status & ~status_rd) | events;
      if (wr && paddr == `ALS_OFF_MASK) begin
        mask <= pwdata[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // pending and committed criteria
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_primary_b <= 1'b0;
      act_primary_b <= 1'b0;
      pend_trig_state <= 24'h000000;
      act_trig_state <= 24'h000000;
      pend_inhib_state <= 24'h000000;
      act_inhib_state <= 24'h000000;
      pend_rst_state <= `ALS_CODE_DISABLED;
      act_rst_state <= `ALS_CODE_DISABLED;
      pend_rst_lead <= 4'h0;
      act_rst_lead <= 4'h0;
      pend_rst_dur <= `ALS_RESET_DUR;
      act_rst_dur <= `ALS_RESET_DUR;
      for (i = 0; i < NL; i = i + 1) begin
        pend_trig_dur[i] <= `ALS_RESET_DUR;
        act_trig_dur[i] <= `ALS_RESET_DUR;
        pend_inhib_dur[i] <= `ALS_RESET_DUR;
        act_inhib_dur[i] <= `ALS_RESET_DUR;
      end
    end else if (commit) begin
      act_primary_b <= pend_primary_b; // RULE7
      act_trig_state <= pend_trig_state;
      act_inhib_state <= pend_inhib_state;
      act_rst_state <= pend_rst_state;
      act_rst_lead <= pend_rst_lead;
      act_rst_dur <= pend_rst_dur;
      for (i = 0; i < NL; i = i + 1) begin
        act_trig_dur[i] <= pend_trig_dur[i];
        act_inhib_dur[i] <= pend_inhib_dur[i];
      end
    end else if (discard) begin
      pend_primary_b <= act_primary_b; // RULE7
      pend_trig_state <= act_trig_state;
      pend_inhib_state <= act_inhib_state;
      pend_rst_state <= act_rst_state;
      pend_rst_lead <= act_rst_lead;
      pend_rst_dur <= act_rst_dur;
      for (i = 0; i < NL; i = i + 1) begin
        pend_trig_dur[i] <= act_trig_dur[i];
        pend_inhib_dur[i] <= act_inhib_dur[i];
      end
    end else if (wr) begin
      case (paddr)
        `ALS_OFF_CTRL: pend_primary_b <= pwdata[`ALS_CTRL_PRIMARY_B]; // RULE1
        `ALS_OFF_TRIG_STATE: pend_trig_state <= pwdata[23:0]; // RULE2
        `ALS_OFF_INHIB_STATE: pend_inhib_state <= pwdata[23:0];
        `ALS_OFF_RESTORE: begin
          pend_rst_state <= pwdata[`ALS_RST_STATE_HI:`ALS_RST_STATE_LO];
          pend_rst_lead <= pwdata[`ALS_RST_LEAD_HI:`ALS_RST_LEAD_LO];
          pend_rst_dur <= pwdata[`ALS_RST_DUR_HI:`ALS_RST_DUR_LO];
        end
        default: begin
          if (in_trig_dur && paddr[1:0] == 2'h0) begin
            pend_trig_dur[dur_idx] <= pwdata[9:0]; // RULE3
          end
          if (in_inhib_dur && paddr[1:0] == 2'h0) begin
            pend_inhib_dur[dur_idx] <= pwdata[9:0]; // RULE3
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read data, captured in the setup cycle
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `ALS_OFF_CTRL: prdata <= {31'h00000000, pend_primary_b};
        `ALS_OFF_TRIG_STATE: prdata <= {8'h00, pend_trig_state};
        `ALS_OFF_INHIB_STATE: prdata <= {8'h00, pend_inhib_state};
        `ALS_OFF_RESTORE: prdata <= {6'h00, pend_rst_dur, 8'h00, pend_rst_lead, 2'h0,
                                     pend_rst_state};
        `ALS_OFF_STATUS: prdata <= {28'h0000000, status};
        `ALS_OFF_MASK: prdata <= {28'h0000000, mask};
        `ALS_OFF_POSITION: prdata <= {16'h0000, trig_cond, 1'b0, inhibit, active_port_b,
                                      switched};
        default: begin
          if (in_trig_dur && paddr[1:0] == 2'h0) begin
            prdata <= {22'h000000, pend_trig_dur[dur_idx]};
          end else if (in_inhib_dur && paddr[1:0] == 2'h0) begin
            prdata <= {22'h000000, pend_inhib_dur[dur_idx]};
          end else begin
            prdata <= 32'h00000000;
          end
        end
      endcase
    end
  end
endmodule // als_switchover

// ==== logic/als_regs.vh ====
// register map, field layout and timing constants of the line switchover block
//
// How it works
// RULE1 - Software picks port A or port B as the primary line and the other port is redundant.
// RULE2 - Each watched lead has a trigger code: disabled, mark, space or no data; disabled never fires.
// RULE3 - Each watched lead has a duration of 1 to 999 seconds that the lead must stay triggered; the code accepts up to 1023, with 0 timed as 1.
// RULE4 - A primary lead held in its trigger state for its duration raises an alarm and switches over.
// RULE5 - While switched, the restore lead held in the complement of its setting switches back.
// RULE6 - A redundant lead held in its configured state for its duration inhibits switchover.
// RULE7 - Software commits new criteria explicitly, and a clear discards the pending ones.
// RULE8 - The switched position survives loss and return of power.
// RULE9 - While lamp test is asserted every indicator is lit.
// RULE10 - Gang switching acts only while the key switch is unlocked.
// RULE11 - The host runs its serial port at the baud rate of the baud select switch; here the host reaches the block through the APB register port instead.
// RULE12 - The host addresses the device with its rack address and password switches; here it selects the block with psel and the register address map instead.
// RULE13 - A lead that leaves its state before the duration expires restarts its timer.
`ifndef ALS_REGS_VH
`define ALS_REGS_VH

`define ALS_OFF_CTRL 12'h000
`define ALS_OFF_TRIG_STATE 12'h004
`define ALS_OFF_INHIB_STATE 12'h008
`define ALS_OFF_RESTORE 12'h00C
`define ALS_OFF_STATUS 12'h010
`define ALS_OFF_MASK 12'h014
`define ALS_OFF_POSITION 12'h018
`define ALS_OFF_TRIG_DUR 12'h040
`define ALS_OFF_INHIB_DUR 12'h080

`define ALS_CTRL_PRIMARY_B 0
`define ALS_CTRL_COMMIT 8
`define ALS_CTRL_CLEAR 9

`define ALS_RST_STATE_LO 0
`define ALS_RST_STATE_HI 1
`define ALS_RST_LEAD_LO 4
`define ALS_RST_LEAD_HI 7
`define ALS_RST_DUR_LO 16
`define ALS_RST_DUR_HI 25

`define ALS_ST_SWITCH 0
`define ALS_ST_FALLBACK 1
`define ALS_ST_INHIBIT 2
`define ALS_ST_GANG 3

`define ALS_POS_SWITCHED 0
`define ALS_POS_ACTIVE_B 1
`define ALS_POS_INHIBIT 2
`define ALS_POS_TRIG_LO 4
`define ALS_POS_TRIG_HI 15

`define ALS_CODE_DISABLED 2'h0
`define ALS_CODE_MARK 2'h1
`define ALS_CODE_SPACE 2'h2
`define ALS_CODE_NODATA 2'h3

`define ALS_NUM_LEADS 12
`define ALS_DUR_BITS 10
`define ALS_RESET_DUR 10'h001

`define ALS_SECOND_NS 1000000000
`define ALS_CLK_NS 50
`define ALS_TICK_CYCLES (`ALS_SECOND_NS / `ALS_CLK_NS)

`endif

// ==== test/als_props.sv ====
// concurrent checks on the ports of the line switchover block
// ---------------------------------------------------------------
// checker
// ---------------------------------------------------------------
module als_props #(
  parameter TICK_CYCLES = 20
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire retained_switched,
  input wire key_unlocked,
  input wire gang_request,
  input wire gang_switched,
  input wire lamp_test,
  input wire switched,
  input wire led_alarm,
  input wire led_line_a,
  input wire led_line_b,
  input wire led_inhibit,
  input wire irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_err_idle; !(psel && penable) |-> !pslverr; endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access phase");
  property p_unmapped; psel && penable && paddr == 12'h100 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_misaligned; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned access not refused");
  property p_lamp; lamp_test |-> led_alarm && led_line_a && led_line_b && led_inhibit; endproperty
  a_lamp: assert property (p_lamp) else $error("indicator dark in lamp test");
  property p_reset_state; presetn && !$past(presetn) |-> !switched && !irq; endproperty
  a_reset_state: assert property (p_reset_state) else $error("state after reset not idle");
  property p_retain; presetn && !$past(presetn) |=> switched == $past(retained_switched);
  endproperty
  a_retain: assert property (p_retain) else $error("position not restored");
  property p_gang;
    $past(presetn) && gang_request && key_unlocked && gang_switched != switched
      |=> switched == $past(gang_switched);
  endproperty
  a_gang: assert property (p_gang) else $error("gang switch not taken");
endmodule // als_props

bind als_switchover als_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .retained_switched(retained_switched),
  .key_unlocked(key_unlocked), .gang_request(gang_request), .gang_switched(gang_switched),
  .lamp_test(lamp_test), .switched(switched), .led_alarm(led_alarm), .led_line_a(led_line_a),
  .led_line_b(led_line_b), .led_inhibit(led_inhibit), .irq(irq));

// ==== test/als_line_model.sv ====
// model of the attached serial equipment driving lead levels and activity
module als_line_model (
  input wire pclk,
  input wire [11:0] a_set,
  input wire [11:0] a_act_set,
  input wire [11:0] b_set,
  input wire [11:0] b_act_set,
  output logic [11:0] a_lead,
  output logic [11:0] a_act,
  output logic [11:0] b_lead,
  output logic [11:0] b_act
);
  timeunit 1ns;
  timeprecision 1ns;
  // leads move only after an edge, so the card never sees a change mid-cycle
  always @(posedge pclk) begin
    a_lead <= a_set;
    a_act <= a_act_set;
    b_lead <= b_set;
    b_act <= b_act_set;
  end
endmodule // als_line_model

// ==== test/als_switchover_test.sv ====
// self-checking bench of the line switchover block
`include "als_regs.vh"
module als_switchover_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr, a_set, b_set, a_act, b_act;
  logic [31:0] pwdata, rd;
  logic retained_switched, key_unlocked, gang_request, gang_switched, lamp_test;
  wire [31:0] prdata;
  wire [11:0] port_a_lead, port_a_activity, port_b_lead, port_b_activity;
  wire pready, pslverr, switched, active_port_b, led_alarm, led_line_a, led_line_b;
  wire led_inhibit, irq;
  int mismatches, comparisons;
  // short tick keeps second-long timers affordable
  als_switchover #(.TICK_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_lead(port_a_lead),
    .port_a_activity(port_a_activity), .port_b_lead(port_b_lead),
    .port_b_activity(port_b_activity), .retained_switched(retained_switched),
    .key_unlocked(key_unlocked), .gang_request(gang_request), .gang_switched(gang_switched),
    .lamp_test(lamp_test), .switched(switched), .active_port_b(active_port_b),
    .led_alarm(led_alarm), .led_line_a(led_line_a), .led_line_b(led_line_b),
    .led_inhibit(led_inhibit), .irq(irq));
  als_line_model u_line (.pclk(pclk), .a_set(a_set), .a_act_set(a_act), .b_set(b_set),
    .b_act_set(b_act), .a_lead(port_a_lead), .a_act(port_a_activity), .b_lead(port_b_lead),
    .b_act(port_b_activity));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    $display("wrong value at %0t: wait timed out", $time);
    give_verdict();
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      give_up();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_sw(input logic exp, input int lim);
    int n;
    n = 0;
    while (switched !== exp && n < lim) begin
      @(negedge pclk);
      n++;
    end
    if (switched !== exp) begin
      give_up();
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {retained_switched, key_unlocked, gang_request, gang_switched, lamp_test} = '0;
    a_set = 12'h000;
    a_act = 12'hFFF;
    b_set = 12'hFFF;
    b_act = 12'hFFF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `ALS_OFF_TRIG_DUR + 12'h008, 0);
    check(rd, 32'h1);
    apb(0, `ALS_OFF_POSITION, 0);
    check(rd, 32'h0);
    apb(0, 12'h100, 0);
    check(rd, 32'h0);
    apb(0, 12'h002, 0);
    idle(80);
    check(switched, 1'b0);
    a_set = 12'hFFF;
    apb(1, `ALS_OFF_TRIG_STATE, 32'h20);
    apb(1, `ALS_OFF_TRIG_DUR + 12'h008, 32'h3);
    apb(1, `ALS_OFF_RESTORE, 32'h00020031);
    apb(1, `ALS_OFF_MASK, 32'hF);
    apb(1, `ALS_OFF_CTRL, 32'h100);
    // a break in the space interval must restart the three second count
    idle(1);
    a_set[2] = 1'b0;
    idle(30);
    a_set[2] = 1'b1;
    idle(2);
    a_set[2] = 1'b0;
    idle(35);
    check(switched, 1'b0);
    wait_sw(1'b1, 40);
    check({led_alarm, led_line_a, led_line_b}, 3'h5);
    check(irq, 1'b1);
    apb(0, `ALS_OFF_STATUS, 0);
    check(rd, 32'h1);
    apb(0, `ALS_OFF_STATUS, 0);
    check(rd, 32'h0);
    idle(1);
    check(irq, 1'b0);
    a_set[2] = 1'b1;
    a_set[3] = 1'b0;
    wait_sw(1'b0, 60);
    apb(0, `ALS_OFF_STATUS, 0);
    check(rd, 32'h2);
    check(led_alarm, 1'b0);
    a_set[3] <= 1'b1;
    apb(1, `ALS_OFF_INHIB_STATE, 32'hC00);
    apb(1, `ALS_OFF_INHIB_DUR + 12'h014, 32'h1);
    apb(1, `ALS_OFF_CTRL, 32'h100);
    idle(1);
    b_act[5] = 1'b0;
    idle(25);
    a_set[2] = 1'b0;
    idle(80);
    check(switched, 1'b0);
    check(led_inhibit, 1'b1);
    apb(0, `ALS_OFF_STATUS, 0);
    check(rd, 32'h4);
    b_act[5] <= 1'b1;
    wait_sw(1'b1, 30);
    a_set[2] = 1'b1;
    a_set[3] = 1'b0;
    wait_sw(1'b0, 60);
    a_set[3] = 1'b1;
    apb(1, `ALS_OFF_MASK, 32'h0);
    apb(0, `ALS_OFF_STATUS, 0);
    @(posedge pclk);
    gang_switched <= 1'b1;
    gang_request <= 1'b1;
    idle(5);
    check(switched, 1'b0);
    @(posedge pclk);
    key_unlocked <= 1'b1;
    idle(2);
    check(switched, 1'b1);
    check(irq, 1'b0);
    apb(1, `ALS_OFF_MASK, 32'h8);
    idle(1);
    check(irq, 1'b1);
    apb(0, `ALS_OFF_STATUS, 0);
    check(rd[3], 1'b1);
    idle(1);
    check(irq, 1'b0);
    @(posedge pclk);
    gang_switched <= 1'b0;
    idle(2);
    check(switched, 1'b0);
    @(posedge pclk);
    gang_request <= 1'b0;
    lamp_test <= 1'b1;
    idle(1);
    check({led_alarm, led_line_a, led_line_b, led_inhibit}, 4'hF);
    @(posedge pclk);
    lamp_test <= 1'b0;
    // a clear throws away a pending duration and keeps the committed one
    apb(1, `ALS_OFF_TRIG_DUR + 12'h014, 32'h7);
    apb(1, `ALS_OFF_CTRL, 32'h200);
    apb(0, `ALS_OFF_TRIG_DUR + 12'h014, 0);
    check(rd, 32'h1);
    // a commit write leaves the pending primary alone, so select first
    apb(1, `ALS_OFF_CTRL, 32'h1);
    apb(1, `ALS_OFF_CTRL, 32'h100);
    apb(0, `ALS_OFF_CTRL, 0);
    check(rd, 32'h1);
    idle(1);
    check(active_port_b, 1'b1);
    @(posedge pclk);
    retained_switched <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    idle(3);
    check(switched, 1'b1);
    check(active_port_b, 1'b1);
    give_verdict();
  end
endmodule // als_switchover_test
